//--- iak_core.sv
// Interrupt acknowledge, priority and nesting control with a Wishbone register slave
// Contract
// RL1 - A source is acknowledgeable only when its request is 1 and mask 0.
// RL2 - Maskable vectoring happens only while the global enable is 1.
// RL3 - Request to servicing takes at least 9, normally at most 14 clocks.
// RL4 - A request just before a subroutine exit may wait longer.
// RL5 - Best programmed level wins; ties go to the best default priority.
// RL6 - A request not taken stays pending until all conditions hold.
// RL7 - Acknowledge pushes status then PC, clears enable, sets level, loads vector.
// RL8 - Maskable handlers end with the maskable return; status word is restored.
// RL9 - The trap instruction always interrupts and can never be disabled.
// RL10 - Trap pushes status then PC, clears enable, loads fixed trap vector.
// RL11 - Trap handlers end with the trap return; status word is restored.
// RL12 - Software never leaves a trap handler with the maskable return.
// RL13 - A handler sets the enable itself to allow nesting.
// RL14 - While enabled, equal or better levels nest; worse ones stay pending. The code nests an equal level only at level 0.
// RL15 - Held requests wait for one interrupted-program instruction after return.
// RL16 - Serviced-level field: 00 level 0/1, 01 level 2, 10 level 3, 11 idle.
// RL17 - Level L is accepted if L is not above the field; trap accepts all.
// RL18 - Two priority bits select level 0 highest through level 3 lowest.
// RL19 - Enable and serviced-level bits live in the status word.
// RL20 - Reset sets the status word to 06h.
// RL21 - After a status, enable or flag register access, defer one instruction.
// RL22 - Decide only at instruction boundaries; give one source id and a strobe.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iak_core import iak_pkg::*; #(
	parameter int NSRC = 8,
	parameter int IDW = 3
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NSRC-1:0] sourceEvent,
	input wire logic instrDone,
	input wire iak_instr_t instrInfo,
	input wire logic [IAK_PC_W-1:0] programCounter,
	input wire logic [7:0] poppedStatus,
	output logic takeInterrupt,
	output logic takeTrap,
	output logic [IDW-1:0] sourceId,
	output iak_push_t stackPush,
	output logic pcLoad,
	output logic [IAK_PC_W-1:0] vectorAddr,
	output logic [7:0] statusWord
);

	iak_state_t state;
	iak_state_t next_state;
	logic [NSRC-1:0] requestFlag;
	logic [NSRC-1:0] maskFlag;
	logic [2*NSRC-1:0] levelSel;
	logic [NSRC-1:0] next_requestFlag;
	logic [7:0] savedStatus;
	logic [IAK_PC_W-1:0] savedPc;
	logic [1:0] takenLevel;
	logic trapActive;
	logic trapInFlight;
	logic regTouched;
	logic found;
	logic [IDW-1:0] winnerId;
	logic [1:0] winnerLevel;
	logic minReached;

	// Register bus decode
	wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire busWrite = busReq & wb_we_i;
	wire [31:0] laneMask = iak_lanes(wb_sel_i);
	wire selStatus = (wb_adr_i == IAK_OFS_STATUS_WORD);
	wire selRequest = (wb_adr_i == IAK_OFS_REQUEST);
	wire selMask = (wb_adr_i == IAK_OFS_MASK);
	wire selLevel = (wb_adr_i == IAK_OFS_LEVEL);
	wire selState = (wb_adr_i == IAK_OFS_STATE);
	wire [31:0] wrStatus = ({24'h000000, statusWord} & ~laneMask) | (wb_dat_i & laneMask);
	wire [31:0] wrRequest = (32'(requestFlag) & ~laneMask) | (wb_dat_i & laneMask);
	wire [31:0] wrMask = (32'(maskFlag) & ~laneMask) | (wb_dat_i & laneMask);
	wire [31:0] wrLevel = (32'(levelSel) & ~laneMask) | (wb_dat_i & laneMask);
	wire [31:0] stateWord = {16'h0000, 3'h0, trapActive, 1'b0, minReached, found, state != ST_IDLE,
		4'(winnerId), 2'h0, winnerLevel};
	wire [31:0] readMux = selStatus ? {24'h000000, statusWord} :
		selRequest ? 32'(requestFlag) :
		selMask ? 32'(maskFlag) :
		selLevel ? 32'(levelSel) :
		selState ? stateWord : 32'h00000000;

	// Status word fields
	wire globalEnable = statusWord[IAK_SW_ENABLE_BIT]; // see RL19
	wire [1:0] servicedLevel = {statusWord[IAK_SW_LVL_BIT1], statusWord[IAK_SW_LVL_BIT0]}; // see RL19

	iak_select #(
		.NSRC(NSRC),
		.IDW(IDW)
	) uSelect (
		.request(requestFlag),
		.mask(maskFlag),
		.levels(levelSel),
		.found(found),
		.winnerId(winnerId),
		.winnerLevel(winnerLevel)
	);

	iak_latency uLatency (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pending(found),
		.restart(pcLoad),
		.minReached(minReached)
	);

	// The instruction that just ended, or a register access during it, defers one boundary
	wire deferBoundary = instrInfo.holdKind | instrInfo.subroutineExit | instrInfo.leaveMaskable |
		instrInfo.leaveTrap | instrInfo.setEnable | instrInfo.clearEnable | regTouched; // see RL4 RL15 RL21
	wire levelAccepted = trapActive || (winnerLevel <= servicedLevel); // see RL14 RL17
	wire boundary = instrDone && (state == ST_IDLE); // see RL22
	wire trapNow = boundary && instrInfo.softTrap; // see RL9
	wire maskableNow = boundary && !instrInfo.softTrap && found && globalEnable && levelAccepted &&
		!deferBoundary; // see RL2 RL6

	assign takeInterrupt = trapNow | maskableNow; // see RL22

	// Level 0 and 1 share the top threshold, so a level 1 handler admits only level 0
	wire [1:0] levelToField = (takenLevel == 2'h0) ? 2'h0 : takenLevel - 2'h1; // see RL16

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (trapNow) begin
					next_state = ST_PSW;
				end else if (maskableNow) begin
					next_state = minReached ? ST_PSW : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (minReached) begin
					next_state = ST_PSW; // see RL3
				end
			end
			ST_PSW: next_state = ST_PC;
			ST_PC: next_state = ST_VEC;
			ST_VEC: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Push order is status word first, then program counter
	always_comb begin
		stackPush = '0;
		if (state == ST_PSW) begin
			stackPush = '{valid: 1'b1, isPc: 1'b0, data: {12'h000, savedStatus}}; // see RL7 RL10
		end else if (state == ST_PC) begin
			stackPush = '{valid: 1'b1, isPc: 1'b1, data: savedPc}; // see RL7 RL10
		end
	end

	assign pcLoad = (state == ST_VEC);
	assign vectorAddr = trapInFlight ? IAK_TRAP_VECTOR :
		IAK_VEC_BASE + {{(IAK_PC_W-IDW-1){1'b0}}, sourceId, 1'b0}; // see RL7 RL10

	// Request flags: hardware events win over a software clear and over the acknowledge clear
	always_comb begin
		next_requestFlag = requestFlag;
		if (busWrite && selRequest) begin
			next_requestFlag = wrRequest[NSRC-1:0];
		end
		if (pcLoad && !trapInFlight) begin
			next_requestFlag[sourceId] = 1'b0;
		end
		next_requestFlag = next_requestFlag | sourceEvent; // see RL6
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			requestFlag <= '0;
			maskFlag <= '1;
			levelSel <= '1;
		end else begin
			state <= next_state;
			requestFlag <= next_requestFlag;
			if (busWrite && selMask) begin
				maskFlag <= wrMask[NSRC-1:0];
			end
			if (busWrite && selLevel) begin
				levelSel <= wrLevel[2*NSRC-1:0];
			end
		end
	end

	// Snapshot taken at the decision so the pushed status is the pre-acknowledge one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			savedStatus <= 8'h00;
			savedPc <= '0;
			sourceId <= '0;
			takenLevel <= IAK_LVL_IDLE;
			trapInFlight <= 1'b0;
			takeTrap <= 1'b0;
		end else begin
			takeTrap <= trapNow;
			if (takeInterrupt) begin
				savedStatus <= statusWord;
				savedPc <= programCounter;
				sourceId <= trapNow ? '0 : winnerId;
				takenLevel <= winnerLevel;
				trapInFlight <= trapNow;
			end
		end
	end

	// Status word update; acknowledge outranks return, enable instructions and bus writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			statusWord <= IAK_SW_RESET; // see RL20
			trapActive <= 1'b0;
		end else begin
			if (pcLoad) begin
				statusWord[IAK_SW_ENABLE_BIT] <= 1'b0; // see RL7 RL10 RL13
				if (!trapInFlight) begin
					statusWord[IAK_SW_LVL_BIT1] <= levelToField[1]; // see RL7 RL16
					statusWord[IAK_SW_LVL_BIT0] <= levelToField[0];
				end
			end else if (boundary && (instrInfo.leaveMaskable || instrInfo.leaveTrap)) begin
				statusWord <= poppedStatus; // see RL8 RL11
			end else if (boundary && instrInfo.setEnable) begin
				statusWord[IAK_SW_ENABLE_BIT] <= 1'b1;
			end else if (boundary && instrInfo.clearEnable) begin
				statusWord[IAK_SW_ENABLE_BIT] <= 1'b0;
			end else if (busWrite && selStatus) begin
				statusWord <= wrStatus[7:0];
			end
			// Only one trap level is tracked; a trap nested in a trap is not counted
			if (pcLoad && trapInFlight) begin
				trapActive <= 1'b1;
			end else if (boundary && instrInfo.leaveTrap) begin
				trapActive <= 1'b0; // see RL11
			end
		end
	end

	// A bus access to a control register marks the running instruction as a holding one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			regTouched <= 1'b0;
		end else if (busReq && (selStatus || selRequest || selMask || selLevel)) begin
			regTouched <= 1'b1; // see RL21
		end else if (instrDone) begin
			regTouched <= 1'b0;
		end
	end

	// Wishbone answers one cycle after the request, unmapped reads as zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			if (busReq && !wb_we_i) begin
				wb_dat_o <= readMux;
			end
		end
	end

endmodule
`default_nettype wire

//--- iak_pkg.sv
// Shared constants and types of the interrupt acknowledge and nesting block
package iak_pkg;

	// Status word layout and reset value
	localparam int IAK_SW_ENABLE_BIT = 7;
	localparam int IAK_SW_LVL_BIT1 = 2;
	localparam int IAK_SW_LVL_BIT0 = 1;
	localparam logic [7:0] IAK_SW_RESET = 8'h06;
	localparam logic [1:0] IAK_LVL_IDLE = 2'h3;

	// Acknowledge latency in CPU clocks
	localparam int IAK_LAT_MIN_CLOCKS = 9;
	localparam int IAK_LAT_MAX_CLOCKS = 14;

	// Register byte offsets
	localparam logic [7:0] IAK_OFS_STATUS_WORD = 8'h00;
	localparam logic [7:0] IAK_OFS_REQUEST = 8'h04;
	localparam logic [7:0] IAK_OFS_MASK = 8'h08;
	localparam logic [7:0] IAK_OFS_LEVEL = 8'h0c;
	localparam logic [7:0] IAK_OFS_STATE = 8'h10;

	// Program counter width and vectors
	localparam int IAK_PC_W = 20;
	localparam logic [19:0] IAK_TRAP_VECTOR = 20'h0007e;
	localparam logic [19:0] IAK_VEC_BASE = 20'h00004;

	// Class of the instruction that completes at a boundary
	typedef struct packed {
		logic holdKind;
		logic subroutineExit;
		logic softTrap;
		logic leaveMaskable;
		logic leaveTrap;
		logic setEnable;
		logic clearEnable;
	} iak_instr_t;

	// One word pushed to the stack
	typedef struct packed {
		logic valid;
		logic isPc;
		logic [19:0] data;
	} iak_push_t;

	typedef enum {ST_IDLE, ST_WAIT, ST_PSW, ST_PC, ST_VEC} iak_state_t;

	function automatic logic [31:0] iak_lanes(input logic [3:0] sel);
		iak_lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

endpackage

//--- iak_select.sv
// Picks the acknowledgeable source with the best level and default priority
`timescale 1ns/1ps
`default_nettype none
module iak_select import iak_pkg::*; #(
	parameter int NSRC = 8,
	parameter int IDW = 3
) (
	input wire logic [NSRC-1:0] request,
	input wire logic [NSRC-1:0] mask,
	input wire logic [2*NSRC-1:0] levels,
	output logic found,
	output logic [IDW-1:0] winnerId,
	output logic [1:0] winnerLevel
);

	logic [NSRC-1:0] eligible;

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : gEligible
			assign eligible[g] = request[g] & ~mask[g]; // see RL1
		end
	endgenerate

	// Scan from the worst default priority so lower indices overwrite on ties
	always_comb begin
		found = 1'b0;
		winnerId = '0;
		winnerLevel = IAK_LVL_IDLE;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (eligible[i] && (!found || levels[2*i +: 2] <= winnerLevel)) begin // see RL5 RL18
				found = 1'b1;
				winnerId = IDW'(i);
				winnerLevel = levels[2*i +: 2];
			end
		end
	end

endmodule
`default_nettype wire

//--- iak_latency.sv
// Counts clocks since an acknowledgeable request became pending
`timescale 1ns/1ps
`default_nettype none
module iak_latency import iak_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pending,
	input wire logic restart,
	output logic minReached
);

	logic [3:0] age;
	logic [3:0] next_age;

	// Saturates so a long-held request never wraps back under the minimum
	assign next_age = (restart || !pending) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
	// Servicing starts the cycle after this, making at least the minimum clocks
	assign minReached = pending && (age >= 4'(IAK_LAT_MIN_CLOCKS - 2)); // see RL3

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 4'h0;
		end else begin
			age <= next_age;
		end
	end

endmodule
`default_nettype wire

//--- iak_core_sva.sv
// Assertion checker for the acknowledge block
`timescale 1ns/1ps
`default_nettype none
module iak_core_sva import iak_pkg::*; #(parameter int IDW = 3) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_ack_o,
	input wire logic instrDone,
	input wire iak_instr_t instrInfo,
	input wire logic [7:0] poppedStatus,
	input wire logic takeInterrupt,
	input wire logic takeTrap,
	input wire logic [IDW-1:0] sourceId,
	input wire iak_push_t stackPush,
	input wire logic pcLoad,
	input wire logic [IAK_PC_W-1:0] vectorAddr,
	input wire logic [7:0] statusWord
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic busy;
	// Boundaries inside a running sequence are ignored by the block
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			busy <= 1'b0;
		else if (takeInterrupt)
			busy <= 1'b1;
		else if (pcLoad)
			busy <= 1'b0;
	end
	a_take_boundary: assert property (takeInterrupt |-> instrDone) else $error("take off boundary");
	a_trap_flag: assert property (takeInterrupt && instrInfo.softTrap |=> takeTrap)
		else $error("trap flag missing");
	a_push_order: assert property (takeInterrupt |-> ##[1:12] stackPush.valid && !stackPush.isPc
		##1 stackPush.valid && stackPush.isPc ##1 pcLoad) else $error("push order wrong");
	a_trap_vector: assert property (takeTrap |-> ##2 pcLoad && vectorAddr == IAK_TRAP_VECTOR)
		else $error("trap vector wrong");
	a_source_vector: assert property (pcLoad && !$past(takeTrap, 2) |->
		vectorAddr == IAK_VEC_BASE + {sourceId, 1'b0}) else $error("source vector wrong");
	a_enable_clear: assert property (pcLoad |=> !statusWord[IAK_SW_ENABLE_BIT])
		else $error("enable not cleared");
	a_enabled_only: assert property (takeInterrupt && !instrInfo.softTrap |-> statusWord[IAK_SW_ENABLE_BIT])
		else $error("taken while disabled");
	a_push_status: assert property (stackPush.valid && !stackPush.isPc |-> stackPush.data[7:0] == statusWord)
		else $error("status push wrong");
	a_reset_word: assert property ($rose(rst_n) |-> statusWord == IAK_SW_RESET) else $error("reset word wrong");
	a_return_pop: assert property (instrDone && !busy && (instrInfo.leaveMaskable || instrInfo.leaveTrap)
		|=> statusWord == $past(poppedStatus)) else $error("status not restored");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule
bind iak_core iak_core_sva #(.IDW(IDW)) i_sva (.sys_clk, .rst_n, .wb_ack_o, .instrDone, .instrInfo,
	.poppedStatus, .takeInterrupt, .takeTrap, .sourceId, .stackPush, .pcLoad, .vectorAddr, .statusWord);
`default_nettype wire

//--- iak_cpu_model.sv
// Behavioural CPU sequencer and stack facing the acknowledge block
`timescale 1ns/1ps
`default_nettype none
module iak_cpu_model import iak_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire iak_instr_t cmd,
	input wire logic takeInterrupt,
	input wire iak_push_t stackPush,
	input wire logic pcLoad,
	input wire logic [IAK_PC_W-1:0] vectorAddr,
	output logic instrDone,
	output iak_instr_t instrInfo,
	output logic [IAK_PC_W-1:0] programCounter,
	output logic [7:0] poppedStatus
);
	logic [19:0] stk [16];
	logic [3:0] sp;
	logic busy;
	wire leave = instrDone && (instrInfo.leaveMaskable || instrInfo.leaveTrap);
	assign poppedStatus = stk[sp - 4'h2][7:0];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			sp <= 4'h0;
			instrDone <= 1'b0;
			instrInfo <= '0;
			programCounter <= '0;
		end else begin
			// The core stalls from the take until the vector is loaded
			if (takeInterrupt)
				busy <= 1'b1;
			else if (pcLoad)
				busy <= 1'b0;
			if (stackPush.valid)
				stk[sp] <= stackPush.data;
			if (stackPush.valid)
				sp <= sp + 4'h1;
			else if (leave)
				sp <= sp - 4'h2;
			if (pcLoad)
				programCounter <= vectorAddr;
			else if (leave)
				programCounter <= stk[sp - 4'h1];
			else if (instrDone)
				programCounter <= programCounter + 20'h1;
			instrDone <= !instrDone && !busy && !stall;
			instrInfo <= cmd;
		end
	end
endmodule
`default_nettype wire

//--- iak_core_tb_top.sv
// Self-checking bench for the acknowledge block
`timescale 1ns/1ps
`default_nettype none
module iak_core_tb_top import iak_pkg::*;;
	localparam iak_instr_t kTrap = 7'h10;
	localparam iak_instr_t kLeaveM = 7'h08;
	localparam iak_instr_t kLeaveT = 7'h04;
	localparam iak_instr_t kSetEn = 7'h02;
	logic sys_clk, rst_n, cyc, stb, we, ack, instrDone, take, trap, pcLoad, stall, slow, tk, got;
	logic [7:0] adr, ev, pop, sw, e, m;
	logic [31:0] wdat, rdat, rdv;
	logic [15:0] l;
	logic [2:0] sid, k, x;
	logic [1:0] lv;
	logic [19:0] pc, vec;
	iak_instr_t info, cmd;
	iak_push_t push;
	int n_fail, samples_checked, seed, nb, lat;
	iak_core #(.NSRC(8), .IDW(3)) i_dut (.sys_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sourceEvent(ev),
		.instrDone, .instrInfo(info), .programCounter(pc), .poppedStatus(pop), .takeInterrupt(take),
		.takeTrap(trap), .sourceId(sid), .stackPush(push), .pcLoad, .vectorAddr(vec), .statusWord(sw));
	iak_cpu_model i_cpu (.sys_clk, .rst_n, .stall, .cmd, .takeInterrupt(take), .stackPush(push), .pcLoad,
		.vectorAddr(vec), .instrDone, .instrInfo(info), .programCounter(pc), .poppedStatus(pop));
	task chk(input string s, input logic [31:0] ex, input logic [31:0] v);
		samples_checked++;
		if (v !== ex) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", s, ex, v);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin @(posedge sys_clk); n++; end while (ack !== 1'b1 && n < 50);
		// A bus that never answers must not let the run pass
		if (ack !== 1'b1) begin
			n_fail++;
			$display("MISMATCH wb ack expected 1 seen %b", ack);
		end
		rdv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task ins(input iak_instr_t c);
		int n;
		n = 0;
		@(posedge sys_clk);
		cmd <= c;
		do begin @(negedge sys_clk); n++; end while (!(instrDone === 1'b1 && info === c) && n < 100);
		if (!(instrDone === 1'b1 && info === c)) begin
			n_fail++;
			$display("MISMATCH instruction expected done seen timeout");
		end
		tk = take;
		@(posedge sys_clk);
		cmd <= '0;
		@(negedge sys_clk);
	endtask
	// One-cycle event pulse; the bench is the only driver of the event lines
	task pulse(input logic [7:0] v);
		@(posedge sys_clk);
		ev <= v;
		@(posedge sys_clk);
		ev <= 8'h00;
	endtask
	task waitTake(input int maxb);
		int c;
		c = 0;
		nb = 0;
		got = 1'b0;
		while (!got && nb <= maxb && c < 300) begin
			@(negedge sys_clk);
			c++;
			if (take === 1'b1)
				got = 1'b1;
			else if (instrDone === 1'b1)
				nb++;
		end
		while (got && pcLoad !== 1'b1 && c < 300) begin
			@(negedge sys_clk);
			c++;
			if (push.valid === 1'b1 && push.isPc === 1'b0)
				lat = c;
		end
		@(negedge sys_clk);
	endtask
	function automatic logic [2:0] best(input logic [7:0] r, input logic [15:0] lvl);
		logic [1:0] b;
		b = 2'h3;
		best = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (r[i] && lvl[2*i+:2] <= b) begin
				b = lvl[2*i+:2];
				best = 3'(i);
			end
	endfunction
	task finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		stall <= slow && ($random(seed) & 1);
	end
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
	initial begin
		{rst_n, cyc, stb, we, slow, adr, ev, wdat, cmd} = '0;
		seed = 32'h342b;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		wb(1'b0, IAK_OFS_STATUS_WORD, 0);
		chk("status", 32'h6, rdv);
		wb(1'b0, IAK_OFS_LEVEL, 0);
		chk("levels", 32'hffff, rdv);
		$display("reset test done");
		slow <= 1'b1;
		// Field 00 before the trap, so only the trap state can admit a level 3 source
		wb(1'b1, IAK_OFS_STATUS_WORD, 32'h80);
		ins(kTrap);
		chk("trap taken", 1, tk);
		while (pcLoad !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		chk("trap status", 32'h0, sw);
		wb(1'b1, IAK_OFS_MASK, 32'h7f);
		ins(kSetEn);
		pulse(8'h80);
		waitTake(8);
		chk("in trap", 7, sid);
		chk("level 3 status", 32'h4, sw);
		ins(kLeaveM);
		chk("nested return", 32'h80, sw);
		ins(kLeaveT);
		chk("trap return", 32'h80, sw);
		ins(7'h01);
		chk("clear enable", 32'h0, sw);
		$display("trap test done");
		slow = 1'b0;
		for (int i = 0; i < 8; i++) begin
			{e, m, l} = 32'($random(seed));
			k = 3'($random(seed));
			e[k] = 1'b1;
			m[k] = 1'b0;
			if (i == 0)
				{e, m, l} = {8'h26, 8'h0, 16'hf7df};
			wb(1'b1, IAK_OFS_REQUEST, 0);
			wb(1'b1, IAK_OFS_MASK, 32'(m));
			wb(1'b1, IAK_OFS_LEVEL, 32'(l));
			wb(1'b1, IAK_OFS_STATUS_WORD, 32'h86);
			pulse(e);
			waitTake(20);
			chk("taken", 1, got);
			x = best(e & ~m, l);
			lv = l[2*x+:2];
			chk("winner", 32'(x), 32'(sid));
			chk("min latency", 1, lat >= IAK_LAT_MIN_CLOCKS);
			chk("max latency", 1, lat <= IAK_LAT_MAX_CLOCKS);
			chk("field", {5'h0, (lv == 2'h0) ? 2'h0 : lv - 2'h1, 1'b0}, sw);
			if (i == 0) begin
				ins(kSetEn);
				waitTake(3);
				chk("lower held", 0, got);
				ins(kLeaveM);
				chk("one instruction", 0, tk);
				waitTake(20);
				chk("pending taken", 32'(best(e & ~m & ~(8'h1 << x), l)), 32'(sid));
			end
			wb(1'b1, IAK_OFS_REQUEST, 0);
			ins(kLeaveM);
		end
		$display("priority test done");
		finish_test();
	end
endmodule
`default_nettype wire
